/* File: rtl/packed_simd_defs.svh */
// Constants of the packed SIMD register file
`ifndef PACKED_SIMD_DEFS_SVH
`define PACKED_SIMD_DEFS_SVH
`define PSIMD_NUM_REGS     8
`define PSIMD_REG_W        64
`define PSIMD_IDX_W        3
`define PSIMD_LO_W         32
`define PSIMD_REG_RESET    64'h0000_0000_0000_0000
`define PSIMD_SW_MAX       16'h7FFF
`define PSIMD_SW_MIN       16'h8000
`define PSIMD_UB_MAX       8'hFF
`define PSIMD_UB_MIN       8'h00
`define PSIMD_SB_MAX       8'h7F
`define PSIMD_SB_MIN       8'h80
`define PSIMD_UW_MAX       16'hFFFF
`define PSIMD_UW_MIN       16'h0000
`endif

/* File: rtl/packed_simd_pkg.sv */
// Types of the packed SIMD register file
package packed_simd_pkg;
    typedef enum logic [1:0] {
        LANE_BYTE  = 2'h0,
        LANE_WORD  = 2'h1,
        LANE_DWORD = 2'h2,
        LANE_QWORD = 2'h3
    } lane_size_t;
    typedef enum logic [3:0] {
        OP_MOVE   = 4'h0,
        OP_ADD    = 4'h1,
        OP_SUB    = 4'h2,
        OP_ADDS   = 4'h3,
        OP_SUBS   = 4'h4,
        OP_ADDUS  = 4'h5,
        OP_SUBUS  = 4'h6,
        OP_AND    = 4'h7,
        OP_ANDN   = 4'h8,
        OP_OR     = 4'h9,
        OP_XOR    = 4'hA,
        OP_CMPEQ  = 4'hB,
        OP_CMPGT  = 4'hC
    } alu_op_t;
    typedef enum logic [1:0] {
        SRC_REG = 2'h0,
        SRC_GP  = 2'h1,
        SRC_MEM = 2'h2
    } src_sel_t;
endpackage : packed_simd_pkg

/* File: rtl/lane_alu_if.sv */
// Operand and result bundle between the register file and its lane datapath
`timescale 1ns/1ps
interface lane_alu_if;
    logic                      [63:0] src_a;
    logic                      [63:0] src_b;
    packed_simd_pkg::alu_op_t         op;
    packed_simd_pkg::lane_size_t      size;
    logic                      [63:0] result;
    modport regs (output src_a, output src_b, output op, output size, input result);
    modport alu  (input src_a, input src_b, input op, input size, output result);
endinterface : lane_alu_if

/* File: rtl/packed_lane_alu.sv */
// Lane-parallel integer datapath for packed bytes, words and doublewords
`timescale 1ns/1ps
`include "packed_simd_defs.svh"
module packed_lane_alu (
    lane_alu_if.alu bus
);
    // ========================================
    // Per-lane results for each lane width
    // ========================================
    logic [63:0] res_b;
    logic [63:0] res_w;
    logic [63:0] res_d;

    function automatic logic [15:0] lane_op(input logic [15:0] a, input logic [15:0] b,
                                            input packed_simd_pkg::alu_op_t op,
                                            input int w);
        logic [16:0] s;
        logic [16:0] d;
        logic [15:0] msk;
        logic [15:0] smax;
        logic [15:0] smin;
        logic [15:0] sa;
        logic [15:0] sb;
        logic [16:0] ss;
        logic [15:0] r;
        msk  = (w == 8) ? 16'h00FF : 16'hFFFF;
        smax = (w == 8) ? {8'h00, `PSIMD_SB_MAX} : `PSIMD_SW_MAX;
        smin = (w == 8) ? {8'hFF, `PSIMD_SB_MIN} : `PSIMD_SW_MIN;
        sa   = (w == 8) ? {{8{a[7]}}, a[7:0]} : a;
        sb   = (w == 8) ? {{8{b[7]}}, b[7:0]} : b;
        s    = {1'b0, a & msk} + {1'b0, b & msk};
        d    = {1'b0, a & msk} - {1'b0, b & msk};
        r    = 16'h0000;
        case (op)
            packed_simd_pkg::OP_ADD:   r = s[15:0];               // [RULE13]
            packed_simd_pkg::OP_SUB:   r = d[15:0];               // [RULE13]
            packed_simd_pkg::OP_ADDS: begin                        // [RULE9] [RULE14]
                // One guard bit so byte and word lanes clamp alike
                ss = {sa[15], sa} + {sb[15], sb};
                if ($signed(ss) > $signed({smax[15], smax})) r = smax;
                else if ($signed(ss) < $signed({smin[15], smin})) r = smin;
                else r = ss[15:0];
            end
            packed_simd_pkg::OP_SUBS: begin                        // [RULE14]
                ss = {sa[15], sa} - {sb[15], sb};
                if ($signed(ss) > $signed({smax[15], smax})) r = smax;
                else if ($signed(ss) < $signed({smin[15], smin})) r = smin;
                else r = ss[15:0];
            end
            packed_simd_pkg::OP_ADDUS: begin                       // [RULE15]
                if (w == 8) r = s[8] ? {8'h00, `PSIMD_UB_MAX} : s[15:0];
                else r = s[16] ? `PSIMD_UW_MAX : s[15:0];
            end
            packed_simd_pkg::OP_SUBUS: begin                       // [RULE15]
                if ((w == 8) ? d[8] : d[16]) r = (w == 8) ? {8'h00, `PSIMD_UB_MIN} : `PSIMD_UW_MIN;
                else r = d[15:0];
            end
            packed_simd_pkg::OP_CMPEQ: r = ((a & msk) == (b & msk)) ? 16'hFFFF : 16'h0000;
            packed_simd_pkg::OP_CMPGT: r = ($signed(sa) > $signed(sb)) ? 16'hFFFF : 16'h0000;
            default:                   r = 16'h0000;
        endcase
        return r & msk;
    endfunction : lane_op

    // Each lane computed independently; carries never cross lanes
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_byte
            logic [15:0] rb;
            assign rb = lane_op({8'h00, bus.src_a[gi*8 +: 8]}, {8'h00, bus.src_b[gi*8 +: 8]},
                                bus.op, 8);
            assign res_b[gi*8 +: 8] = rb[7:0];                    // [RULE5] [RULE6]
        end
        for (gi = 0; gi < 4; gi++) begin : g_word
            assign res_w[gi*16 +: 16] = lane_op(bus.src_a[gi*16 +: 16], bus.src_b[gi*16 +: 16],
                                                bus.op, 16);      // [RULE5] [RULE6]
        end
        for (gi = 0; gi < 2; gi++) begin : g_dword
            logic [31:0] a32;
            logic [31:0] b32;
            logic [32:0] s32;
            logic [32:0] d32;
            assign a32 = bus.src_a[gi*32 +: 32];
            assign b32 = bus.src_b[gi*32 +: 32];
            assign s32 = {1'b0, a32} + {1'b0, b32};
            assign d32 = {1'b0, a32} - {1'b0, b32};
            // Doubleword lanes support only wraparound forms and compares
            assign res_d[gi*32 +: 32] =
                (bus.op == packed_simd_pkg::OP_ADD)   ? s32[31:0] :   // [RULE13]
                (bus.op == packed_simd_pkg::OP_SUB)   ? d32[31:0] :
                (bus.op == packed_simd_pkg::OP_CMPEQ) ? {32{a32 == b32}} :
                (bus.op == packed_simd_pkg::OP_CMPGT) ? {32{$signed(a32) > $signed(b32)}} :
                32'h0000_0000;
        end
    endgenerate

    // ========================================
    // Whole-quadword logic and result select
    // ========================================
    logic [63:0] res_q;
    assign res_q =
        (bus.op == packed_simd_pkg::OP_AND)  ? (bus.src_a & bus.src_b) :
        (bus.op == packed_simd_pkg::OP_ANDN) ? (~bus.src_a & bus.src_b) :
        (bus.op == packed_simd_pkg::OP_OR)   ? (bus.src_a | bus.src_b) :
        (bus.op == packed_simd_pkg::OP_XOR)  ? (bus.src_a ^ bus.src_b) :
        bus.src_b;                                                // [RULE3]

    logic is_logic;
    assign is_logic = (bus.op == packed_simd_pkg::OP_MOVE) || (bus.op == packed_simd_pkg::OP_AND)
                   || (bus.op == packed_simd_pkg::OP_ANDN) || (bus.op == packed_simd_pkg::OP_OR)
                   || (bus.op == packed_simd_pkg::OP_XOR);
    assign bus.result = is_logic ? res_q :
                        (bus.size == packed_simd_pkg::LANE_BYTE)  ? res_b :
                        (bus.size == packed_simd_pkg::LANE_WORD)  ? res_w :
                        (bus.size == packed_simd_pkg::LANE_DWORD) ? res_d : res_q;
endmodule : packed_lane_alu

/* File: rtl/packed_simd_regfile.sv */
// Packed SIMD register file aliased onto the floating-point data stack
// Operation
// (RULE1) Eight registers of 64 bits hold packed integer data.
// (RULE2) Packed registers share storage with the eight floating-point stack entries.
// (RULE3) Quadword moves, pack, logical and arithmetic work use full 64 bits.
// (RULE4) A 32-bit path serves doubleword memory, general-register moves, some unpacks.
// (RULE5) A register reads as eight bytes, four words or two doublewords.
// (RULE6) Transfers move whole 64-bit blocks; arithmetic acts on each lane alone.
// (RULE7) Memory images put the least significant element at the lowest address.
// (RULE8) Register bit layout equals the memory quadword layout, no reordering.
// (RULE9) Signed word saturating add combines four word lanes into four results.
// (RULE10) Packed registers never form memory addresses; only general registers do.
// (RULE11) Some operations take operands from or write to general registers.
// (RULE12) Behaviour is identical in every execution mode; no new mode.
// (RULE13) Wraparound arithmetic drops each lane's carry, keeping low bits.
// (RULE14) Signed word saturation clamps to 7FFF and 8000.
// (RULE15) Unsigned byte saturation clamps to FF and 00.
// (RULE16) Lane overflow raises no exception and touches no flag.
// (RULE17) A write is visible to any read issued in a later cycle.
`timescale 1ns/1ps
`include "packed_simd_defs.svh"
module packed_simd_regfile #(
    parameter int NUM_REGS = `PSIMD_NUM_REGS,
    parameter int REG_W    = `PSIMD_REG_W
) (
    input  wire logic                                 core_clk,
    input  wire logic                                 rst_b,
    // Packed operation issue
    input  wire logic                                 op_valid,
    input  wire packed_simd_pkg::alu_op_t             op_code,
    input  wire packed_simd_pkg::lane_size_t          op_size,
    input  wire logic [`PSIMD_IDX_W-1:0]              op_dst,
    input  wire logic [`PSIMD_IDX_W-1:0]              op_src_a,
    input  wire logic [`PSIMD_IDX_W-1:0]              op_src_b,
    input  wire packed_simd_pkg::src_sel_t            op_b_sel,
    input  wire logic                                 op_narrow,
    input  wire logic                                 op_dst_gp,
    input  wire logic [31:0]                          gp_operand,
    input  wire logic [63:0]                          mem_rd_data,
    output logic      [31:0]                          gp_result,
    output logic                                      gp_result_valid,
    // Memory store image
    input  wire logic                                 st_valid,
    input  wire logic [`PSIMD_IDX_W-1:0]              st_src,
    input  wire logic                                 st_narrow,
    output logic      [63:0]                          st_data,
    output logic      [7:0]                           st_byte_en,
    output logic                                      st_data_valid,
    // Floating-point stack view
    input  wire logic                                 fp_wr_en,
    input  wire logic [`PSIMD_IDX_W-1:0]              fp_wr_idx,
    input  wire logic [63:0]                          fp_wr_mant,
    input  wire logic [`PSIMD_IDX_W-1:0]              fp_rd_idx,
    output logic      [63:0]                          fp_rd_mant,
    // Packed register read port
    input  wire logic [`PSIMD_IDX_W-1:0]              rd_idx,
    output logic      [63:0]                          rd_data
);
    // ========================================
    // Elaboration checks
    // ========================================
    if (NUM_REGS != 8 || REG_W != 64) begin : g_bad_params
        $error("packed_simd_regfile supports eight 64-bit registers only");
    end

    // ========================================
    // Shared storage for both views
    // ========================================
    logic [REG_W-1:0] regs_ff [NUM_REGS];                          // [RULE1]

    lane_alu_if alu_bus ();

    logic [63:0] rd_a;
    logic [63:0] rd_b_reg;
    logic [63:0] gp_ext;
    logic [63:0] mem_lo;
    logic [63:0] opnd_b;
    logic [63:0] alu_res;
    logic [63:0] pk_wr_val;
    logic        pk_wr_en;

    function automatic logic [63:0] zext32(input logic [31:0] v);
        return {32'h0000_0000, v};
    endfunction : zext32

    assign rd_a     = regs_ff[op_src_a];
    assign rd_b_reg = regs_ff[op_src_b];
    assign gp_ext   = zext32(gp_operand);                          // [RULE4] [RULE11]
    // Memory data arrives already in register layout: byte n at address base+n
    assign mem_lo   = op_narrow ? zext32(mem_rd_data[31:0]) : mem_rd_data; // [RULE7] [RULE8]
    assign opnd_b   = (op_b_sel == packed_simd_pkg::SRC_GP)  ? gp_ext :
                      (op_b_sel == packed_simd_pkg::SRC_MEM) ? mem_lo : rd_b_reg;

    assign alu_bus.src_a = rd_a;
    assign alu_bus.src_b = opnd_b;
    assign alu_bus.op    = op_code;
    assign alu_bus.size  = op_size;
    assign alu_res       = alu_bus.result;

    packed_lane_alu u_alu (
        .bus (alu_bus.alu)
    );

    // A narrow move zero-extends into the packed register
    assign pk_wr_val = (op_narrow && op_code == packed_simd_pkg::OP_MOVE) ? zext32(opnd_b[31:0])
                                                                          : alu_res; // [RULE4]
    // No mode input exists, so every operation decodes alike in all modes [RULE12]
    assign pk_wr_en  = op_valid && !op_dst_gp;

    // ========================================
    // Register writes from either view
    // ========================================
    // Packed write takes precedence when both views target the same entry
    genvar gr;
    generate
        for (gr = 0; gr < NUM_REGS; gr++) begin : g_reg
            logic hit_pk;
            logic hit_fp;
            assign hit_pk = pk_wr_en && (op_dst == (`PSIMD_IDX_W)'(gr));
            assign hit_fp = fp_wr_en && (fp_wr_idx == (`PSIMD_IDX_W)'(gr));
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    regs_ff[gr] <= `PSIMD_REG_RESET;
                end else if (hit_pk) begin
                    regs_ff[gr] <= pk_wr_val;                       // [RULE2] [RULE17]
                end else if (hit_fp) begin
                    regs_ff[gr] <= fp_wr_mant;                      // [RULE2]
                end
            end
        end
    endgenerate

    // ========================================
    // Read views and registered outputs
    // ========================================
    assign rd_data    = regs_ff[rd_idx];                           // [RULE17]
    assign fp_rd_mant = regs_ff[fp_rd_idx];                        // [RULE2]

    // No flag or exception output exists for lane overflow [RULE16]
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            gp_result       <= 32'h0000_0000;
            gp_result_valid <= 1'b0;
        end else begin
            gp_result       <= op_valid && op_dst_gp ? rd_a[31:0] : gp_result; // [RULE4] [RULE11]
            gp_result_valid <= op_valid && op_dst_gp;
        end
    end

    // Stores carry the register image unchanged; memory address comes from elsewhere
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_data       <= 64'h0000_0000_0000_0000;
            st_byte_en    <= 8'h00;
            st_data_valid <= 1'b0;
        end else begin
            st_data       <= st_valid ? regs_ff[st_src] : st_data;  // [RULE6] [RULE8] [RULE10]
            st_byte_en    <= st_valid ? (st_narrow ? 8'h0F : 8'hFF) : 8'h00; // [RULE3] [RULE4]
            st_data_valid <= st_valid;
        end
    end

    // ========================================
    // Assertions
    // ========================================
    property p_pk_write_visible;
        logic [2:0] d;
        logic [63:0] v;
        @(posedge core_clk) disable iff (!rst_b)
        (pk_wr_en, d = op_dst, v = pk_wr_val) |=> (regs_ff[d] == v);
    endproperty
    a_pk_write_visible: assert property (p_pk_write_visible) else $error("packed write lost"); // [RULE17]

    property p_alias;
        @(posedge core_clk) disable iff (!rst_b)
        (fp_wr_en && !(pk_wr_en && op_dst == fp_wr_idx)) |=>
            (regs_ff[$past(fp_wr_idx)] == $past(fp_wr_mant));
    endproperty
    a_alias: assert property (p_alias) else $error("stack write not seen in packed view"); // [RULE2]

    property p_fp_view;
        @(posedge core_clk) disable iff (!rst_b)
        pk_wr_en |=> (fp_rd_idx != $past(op_dst)) || (fp_rd_mant == $past(pk_wr_val));
    endproperty
    a_fp_view: assert property (p_fp_view) else $error("views disagree"); // [RULE2]

    property p_store_image;
        @(posedge core_clk) disable iff (!rst_b)
        st_valid |=> st_data_valid && st_data == $past(regs_ff[st_src])
                     && st_byte_en == ($past(st_narrow) ? 8'h0F : 8'hFF);
    endproperty
    a_store_image: assert property (p_store_image) else $error("store image wrong"); // [RULE8]

    property p_gp_out;
        @(posedge core_clk) disable iff (!rst_b)
        (op_valid && op_dst_gp) |=> gp_result_valid && gp_result == $past(rd_a[31:0]);
    endproperty
    a_gp_out: assert property (p_gp_out) else $error("gp result wrong"); // [RULE11]

    property p_narrow_move;
        @(posedge core_clk) disable iff (!rst_b)
        (pk_wr_en && op_narrow && op_code == packed_simd_pkg::OP_MOVE) |=>
            (regs_ff[$past(op_dst)][63:32] == 32'h0000_0000);
    endproperty
    a_narrow_move: assert property (p_narrow_move) else $error("narrow move not extended"); // [RULE4]

    property p_sat_word;
        @(posedge core_clk) disable iff (!rst_b)
        (op_code == packed_simd_pkg::OP_ADDS && op_size == packed_simd_pkg::LANE_WORD
         && !rd_a[15] && !opnd_b[15] && alu_res[15]) |-> 1'b0;
    endproperty
    a_sat_word: assert property (p_sat_word) else $error("signed word overflow wrapped"); // [RULE14]

    property p_sat_ubyte;
        @(posedge core_clk) disable iff (!rst_b)
        (op_code == packed_simd_pkg::OP_ADDUS && op_size == packed_simd_pkg::LANE_BYTE
         && ({1'b0, rd_a[7:0]} + {1'b0, opnd_b[7:0]}) > 9'h0FF) |-> (alu_res[7:0] == 8'hFF);
    endproperty
    a_sat_ubyte: assert property (p_sat_ubyte) else $error("unsigned byte not clamped"); // [RULE15]

    property p_wrap_word;
        @(posedge core_clk) disable iff (!rst_b)
        (op_code == packed_simd_pkg::OP_ADD && op_size == packed_simd_pkg::LANE_WORD) |->
            (alu_res[31:16] == 16'(rd_a[31:16] + opnd_b[31:16]));
    endproperty
    a_wrap_word: assert property (p_wrap_word) else $error("lane carry leaked"); // [RULE13]

    c_pk_write: cover property (@(posedge core_clk) disable iff (!rst_b) pk_wr_en);
    c_fp_write: cover property (@(posedge core_clk) disable iff (!rst_b) fp_wr_en);
    c_sat_add:  cover property (@(posedge core_clk) disable iff (!rst_b)
                                op_valid && op_code == packed_simd_pkg::OP_ADDS);
    c_store:    cover property (@(posedge core_clk) disable iff (!rst_b) st_valid && st_narrow);
endmodule : packed_simd_regfile

/* File: verification/line_memory_model.sv */
// Quadword memory image on the pipeline side: supplies loads, takes store images
`timescale 1ns/1ps
module line_memory_model (
    input  wire logic        core_clk,
    input  wire logic        st_data_valid,
    input  wire logic [63:0] st_data,
    input  wire logic [7:0]  st_byte_en,
    output logic      [63:0] mem_rd_data
);
    logic [7:0] mem_ff [8];
    // Byte n lives at address n; preset to n+1 so lane order is visible
    initial begin
        for (int n = 0; n < 8; n++) begin
            mem_ff[n] = 8'(n + 1);
        end
    end
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            mem_rd_data[8*n +: 8] = mem_ff[n];
        end
    end
    always @(posedge core_clk) begin
        if (st_data_valid === 1'b1) begin
            for (int n = 0; n < 8; n++) begin
                if (st_byte_en[n]) begin
                    mem_ff[n] <= st_data[8*n +: 8];
                end
            end
        end
    end
endmodule : line_memory_model

/* File: verification/packed_simd_register_file_test.sv */
// Self-checking bench for the packed SIMD register file
`timescale 1ns/1ps
module packed_simd_register_file_test;
    logic core_clk, rst_b, op_valid, op_narrow, op_dst_gp, st_valid, st_narrow, fp_wr_en;
    packed_simd_pkg::alu_op_t    op_code;
    packed_simd_pkg::lane_size_t op_size;
    packed_simd_pkg::src_sel_t   op_b_sel;
    logic [2:0]  op_dst, op_src_a, op_src_b, st_src, fp_wr_idx, fp_rd_idx, rd_idx;
    logic [31:0] gp_operand, gp_result;
    logic [63:0] mem_rd_data, st_data, fp_wr_mant, fp_rd_mant, rd_data;
    logic [7:0]  st_byte_en;
    logic        gp_result_valid, st_data_valid;
    int          failures, checks;
    localparam logic [63:0] VAL_A = 64'h7FFF_8000_0001_FFFF;
    localparam logic [63:0] VAL_B = 64'h0001_FFFF_0001_0001;

    packed_simd_regfile DUT (
        .core_clk(core_clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
        .op_size(op_size), .op_dst(op_dst), .op_src_a(op_src_a), .op_src_b(op_src_b),
        .op_b_sel(op_b_sel), .op_narrow(op_narrow), .op_dst_gp(op_dst_gp),
        .gp_operand(gp_operand), .mem_rd_data(mem_rd_data), .gp_result(gp_result),
        .gp_result_valid(gp_result_valid), .st_valid(st_valid), .st_src(st_src),
        .st_narrow(st_narrow), .st_data(st_data), .st_byte_en(st_byte_en),
        .st_data_valid(st_data_valid), .fp_wr_en(fp_wr_en), .fp_wr_idx(fp_wr_idx),
        .fp_wr_mant(fp_wr_mant), .fp_rd_idx(fp_rd_idx), .fp_rd_mant(fp_rd_mant),
        .rd_idx(rd_idx), .rd_data(rd_data)
    );
    line_memory_model mem (
        .core_clk(core_clk), .st_data_valid(st_data_valid), .st_data(st_data),
        .st_byte_en(st_byte_en), .mem_rd_data(mem_rd_data)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ==========================================
    // Access tasks
    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic issue(input packed_simd_pkg::alu_op_t c, input packed_simd_pkg::lane_size_t s,
                         input logic [2:0] d, input logic [2:0] a,
                         input packed_simd_pkg::src_sel_t bs, input logic nr, input logic gp);
        @(posedge core_clk);
        op_valid  <= 1'b1;
        op_code   <= c;
        op_size   <= s;
        op_dst    <= d;
        op_src_a  <= a;
        op_src_b  <= (c == packed_simd_pkg::OP_MOVE) ? a : 3'h1;
        op_b_sel  <= bs;
        op_narrow <= nr;
        op_dst_gp <= gp;
        @(posedge core_clk);
        op_valid  <= 1'b0;
        #1;
    endtask : issue

    // Reads both views of one entry in the cycle after any write
    task automatic peek(input logic [2:0] i, input logic [63:0] exp);
        @(posedge core_clk);
        rd_idx    <= i;
        fp_rd_idx <= i;
        #1;
        check(rd_data, exp, "packed view");
        check(fp_rd_mant, exp, "stack view");
    endtask : peek

    task automatic fp_write(input logic [2:0] i, input logic [63:0] v);
        @(posedge core_clk);
        fp_wr_en   <= 1'b1;
        fp_wr_idx  <= i;
        fp_wr_mant <= v;
        @(posedge core_clk);
        fp_wr_en   <= 1'b0;
    endtask : fp_write

    task automatic run(input packed_simd_pkg::alu_op_t c, input packed_simd_pkg::lane_size_t s,
                       input logic [63:0] exp);
        issue(c, s, 3'h3, 3'h0, packed_simd_pkg::SRC_REG, 1'b0, 1'b0);
        peek(3'h3, exp);
    endtask : run

    task automatic store(input logic [2:0] i, input logic nr, input logic [63:0] exp,
                         input logic [7:0] en);
        @(posedge core_clk);
        st_valid  <= 1'b1;
        st_src    <= i;
        st_narrow <= nr;
        @(posedge core_clk);
        st_valid  <= 1'b0;
        #1;
        for (int n = 0; n < 4 && st_data_valid !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        check({63'h0, st_data_valid}, 64'h1, "store valid");
        check(st_data, exp, "store image");
        check({56'h0, st_byte_en}, {56'h0, en}, "store lanes");
    endtask : store

    task automatic final_report;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    // ==========================================
    // Tests
    initial begin
        {rst_b, op_valid, op_narrow, op_dst_gp, st_valid, st_narrow, fp_wr_en} = '0;
        {op_dst, op_src_a, op_src_b, st_src, fp_wr_idx, fp_rd_idx, rd_idx} = '0;
        op_code = packed_simd_pkg::OP_MOVE;
        op_size = packed_simd_pkg::LANE_WORD;
        op_b_sel = packed_simd_pkg::SRC_REG;
        gp_operand = 32'h89AB_CDEF;
        fp_wr_mant = '0;
        failures = 0;
        checks = 0;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) peek(3'(i), 64'h0);
        $display("test reset done");
        fp_write(3'h0, VAL_A);
        fp_write(3'h1, VAL_B);
        peek(3'h0, VAL_A);
        peek(3'h1, VAL_B);
        $display("test aliasing done");
        run(packed_simd_pkg::OP_ADDS, packed_simd_pkg::LANE_WORD, 64'h7FFF_8000_0002_0000);
        run(packed_simd_pkg::OP_ADD, packed_simd_pkg::LANE_WORD, 64'h8000_7FFF_0002_0000);
        run(packed_simd_pkg::OP_ADD, packed_simd_pkg::LANE_DWORD, 64'h8001_7FFF_0003_0000);
        run(packed_simd_pkg::OP_SUB, packed_simd_pkg::LANE_BYTE, 64'h7FFE_8101_0000_FFFE);
        run(packed_simd_pkg::OP_SUBS, packed_simd_pkg::LANE_WORD, 64'h7FFE_8001_0000_FFFE);
        run(packed_simd_pkg::OP_ADDUS, packed_simd_pkg::LANE_BYTE, 64'h7FFF_FFFF_0002_FFFF);
        run(packed_simd_pkg::OP_SUBUS, packed_simd_pkg::LANE_BYTE, 64'h7FFE_0000_0000_FFFE);
        run(packed_simd_pkg::OP_AND, packed_simd_pkg::LANE_BYTE, 64'h0001_8000_0001_0001);
        run(packed_simd_pkg::OP_ANDN, packed_simd_pkg::LANE_BYTE, 64'h0000_7FFF_0000_0000);
        run(packed_simd_pkg::OP_OR, packed_simd_pkg::LANE_BYTE, 64'h7FFF_FFFF_0001_FFFF);
        run(packed_simd_pkg::OP_XOR, packed_simd_pkg::LANE_BYTE, 64'h7FFE_7FFF_0000_FFFE);
        run(packed_simd_pkg::OP_CMPEQ, packed_simd_pkg::LANE_WORD, 64'h0000_0000_FFFF_0000);
        run(packed_simd_pkg::OP_CMPGT, packed_simd_pkg::LANE_WORD, 64'hFFFF_0000_0000_0000);
        run(packed_simd_pkg::OP_MOVE, packed_simd_pkg::LANE_QWORD, VAL_A);
        $display("test lane ops done");
        issue(packed_simd_pkg::OP_OR, packed_simd_pkg::LANE_QWORD, 3'h2, 3'h7,
              packed_simd_pkg::SRC_MEM, 1'b0, 1'b0);
        peek(3'h2, 64'h0807_0605_0403_0201);
        issue(packed_simd_pkg::OP_OR, packed_simd_pkg::LANE_QWORD, 3'h4, 3'h7,
              packed_simd_pkg::SRC_MEM, 1'b1, 1'b0);
        peek(3'h4, 64'h0000_0000_0403_0201);
        issue(packed_simd_pkg::OP_OR, packed_simd_pkg::LANE_QWORD, 3'h5, 3'h7,
              packed_simd_pkg::SRC_GP, 1'b1, 1'b0);
        peek(3'h5, 64'h0000_0000_89AB_CDEF);
        issue(packed_simd_pkg::OP_MOVE, packed_simd_pkg::LANE_QWORD, 3'h6, 3'h0,
              packed_simd_pkg::SRC_REG, 1'b1, 1'b1);
        for (int n = 0; n < 4 && gp_result_valid !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        check({63'h0, gp_result_valid}, 64'h1, "gp valid");
        check({32'h0, gp_result}, 64'h0001_FFFF, "gp result");
        peek(3'h6, 64'h0);
        $display("test load and general register done");
        store(3'h0, 1'b1, VAL_A, 8'h0F);
        @(posedge core_clk);
        #1;
        check(mem_rd_data, 64'h0807_0605_0001_FFFF, "narrow store memory");
        store(3'h1, 1'b0, VAL_B, 8'hFF);
        @(posedge core_clk);
        #1;
        check(mem_rd_data, VAL_B, "full store memory");
        $display("test store done");
        final_report();
    end

    initial begin
        #200us;
        failures++;
        $display("BAD t=%0t watchdog expired", $time);
        final_report();
    end
endmodule : packed_simd_register_file_test
